// >>> rtl/sst_exec.sv
`timescale 1ns/100ps
// Operation
// - Decode subtract accumulator from file register
// - Two's complement; update N OV C DC Z
// - Destination bit selects accumulator or file
// - Bank bit selects access bank or bank
// - Subtract with borrow uses inverted carry
// - Nibble exchange, no flags, one cycle
// - Table read pointer update by nn field
// - Table read copies byte into latch
// - Pointer bit 0 selects low/high byte
// - Table read two cycles, access in second
// - Power-down sets timeout, clears power-down flag
// - Test file, skip next when zero
// - Decode, read, process, write phases
// - Power-down clears watchdog, stops phase clock
module sst_exec #(
  parameter int PWORDS = sst_pkg::PWORDS_DEF,
  parameter int PHASE_DIV = sst_pkg::PHASE_DIV_DEF,
  parameter logic [31:0] WDT_CYCLES = sst_pkg::WDT_CYCLES_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [sst_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [sst_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  localparam int PAW = $clog2(PWORDS);
  localparam int DAW = sst_pkg::BANK_W + 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////
  // Storage and state

  logic [7:0] dmem [0:(1<<DAW)-1];
  logic [sst_pkg::PWORD_W-1:0] pmem [0:PWORDS-1];

  sst_pkg::sst_state_e state_r;
  sst_pkg::sst_dec_s dec_r;
  sst_pkg::sst_alu_s alu_r;
  sst_pkg::sst_alu_s alu_nxt;
  logic [15:0] instr_r;
  logic [7:0] acc_r;
  logic [4:0] flags_r;
  logic to_r;
  logic pd_r;
  logic skip_r;
  logic [sst_pkg::BANK_W-1:0] bank_r;
  logic [sst_pkg::PTR_W-1:0] ptr_r;
  logic [7:0] latch_r;
  logic [DAW-1:0] daddr_r;
  logic [PAW-1:0] paddr_r;
  logic [7:0] fval_r;
  logic [31:0] wdt_r;
  logic [31:0] rdata_nxt;
  logic [1:0] ph;
  logic tick;
  logic run;
  logic idle;
  logic wr_fire;
  logic wr_ok;
  logic launch;
  logic end_ph1;
  logic end_ph2;
  logic end_ph3;
  logic wdt_hit;
  logic [DAW-1:0] eff_addr;
  logic [sst_pkg::PTR_W-1:0] rd_ptr;
  logic [sst_pkg::PWORD_W-1:0] rd_word;
  logic writes_dest;

  // Offsets that answer on the bus
  function automatic logic mapped(logic [sst_pkg::ADDR_W-1:0] a);
    case (a)
      sst_pkg::OFF_INSTR, sst_pkg::OFF_STATUS, sst_pkg::OFF_ACC,
      sst_pkg::OFF_BANK, sst_pkg::OFF_PTR, sst_pkg::OFF_LATCH,
      sst_pkg::OFF_DADDR, sst_pkg::OFF_DDATA, sst_pkg::OFF_PADDR,
      sst_pkg::OFF_PDATA: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction : mapped

  ////////////////////////////////////////////////////////////////////////
  // Instruction clock: four phases, stopped outside execution

  assign run = (state_r == sst_pkg::S_EXEC) ||
               (state_r == sst_pkg::S_TBL2);

  sst_phase #(
    .DIV(PHASE_DIV)
  ) u_phase (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(run),
    .ph(ph),
    .tick(tick)
  );

  // Phase ends: read register, process data, write destination
  assign end_ph1 = tick && (ph == 2'h1);
  assign end_ph2 = tick && (ph == 2'h2);
  assign end_ph3 = tick && (ph == 2'h3);

  ////////////////////////////////////////////////////////////////////////
  // Operand addressing and arithmetic

  // Access bank is bank zero; otherwise bank register sits above operand
  assign eff_addr = dec_r.bank_a ? {bank_r, dec_r.faddr}
                    : {{sst_pkg::BANK_W{1'b0}}, dec_r.faddr};

  sst_alu u_alu (
    .op(dec_r.op),
    .fval(fval_r),
    .acc(acc_r),
    .carry(flags_r[sst_pkg::FL_C]),
    .o(alu_nxt)
  );

  assign writes_dest = (dec_r.op == sst_pkg::OP_SUB) ||
                       (dec_r.op == sst_pkg::OP_SUBB) ||
                       (dec_r.op == sst_pkg::OP_SWAP);

  // Pre-increment reads the next byte; other modes read the pointer itself
  assign rd_ptr = (dec_r.nn == sst_pkg::NN_PREINC) ?
                  ptr_r + 21'h000001 : ptr_r;
  // Word index wraps when the pointer runs past the memory held here
  assign rd_word = pmem[rd_ptr[PAW:1]];

  ////////////////////////////////////////////////////////////////////////
  // Bus control signals

  assign idle = (state_r == sst_pkg::S_IDLE);
  assign wr_fire = s_axi_awready;
  // Writes while busy or asleep are refused so state never races the core
  assign wr_ok = wr_fire && idle && mapped(s_axi_awaddr);
  assign launch = wr_ok && (s_axi_awaddr == sst_pkg::OFF_INSTR);
  assign wdt_hit = (wdt_r == WDT_CYCLES - 32'h00000001);

  ////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= sst_pkg::S_IDLE;
    end else begin
      case (state_r)
        sst_pkg::S_IDLE: begin
          if (launch) state_r <= sst_pkg::S_EXEC;
        end
        sst_pkg::S_EXEC: begin
          if (end_ph3) begin
            if (dec_r.op == sst_pkg::OP_TBL)
              state_r <= sst_pkg::S_TBL2;
            else if (dec_r.op == sst_pkg::OP_SLEEP)
              state_r <= sst_pkg::S_SLEEP;
            else state_r <= sst_pkg::S_IDLE;
          end
        end
        sst_pkg::S_TBL2: begin
          if (end_ph3) state_r <= sst_pkg::S_IDLE;
        end
        sst_pkg::S_SLEEP: begin
          if (wdt_hit) state_r <= sst_pkg::S_IDLE;
        end
        default: state_r <= sst_pkg::S_IDLE;
      endcase
    end
  end

  // Capture the instruction; a pending skip turns it into a no-op
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      instr_r <= 16'h0000;
      dec_r <= sst_pkg::sst_decode(16'h0000);
    end else if (launch) begin
      instr_r <= s_axi_wdata[15:0];
      dec_r <= sst_pkg::sst_decode(s_axi_wdata[15:0]);
      if (skip_r) dec_r.op <= sst_pkg::OP_NOP;
    end
  end

  // Skip request from a zero test; cleared by the next instruction
  always_ff @(posedge aclk) begin
    if (!aresetn) skip_r <= 1'b0;
    else if (state_r == sst_pkg::S_EXEC && end_ph3)
      skip_r <= (dec_r.op == sst_pkg::OP_TST) && (fval_r == 8'h00);
  end

  // Operand read in the second phase, result held in the third
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fval_r <= 8'h00;
      alu_r <= '0;
    end else if (state_r == sst_pkg::S_EXEC) begin
      if (end_ph1) fval_r <= dmem[eff_addr];
      if (end_ph2) alu_r <= alu_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Memories: the core writes only in the last phase, software when idle

  always_ff @(posedge aclk) begin
    if (state_r == sst_pkg::S_EXEC && end_ph3 && writes_dest &&
        dec_r.dest_f)
      dmem[eff_addr] <= alu_r.res;
    else if (wr_ok && s_axi_awaddr == sst_pkg::OFF_DDATA && s_axi_wstrb[0])
      dmem[daddr_r] <= s_axi_wdata[7:0];
  end

  always_ff @(posedge aclk) begin
    if (wr_ok && s_axi_awaddr == sst_pkg::OFF_PDATA)
      pmem[paddr_r] <= 16'(sst_pkg::sst_wmerge({16'h0000, pmem[paddr_r]},
                       s_axi_wdata, s_axi_wstrb));
  end

  ////////////////////////////////////////////////////////////////////////
  // Working accumulator and flags

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_r <= sst_pkg::ACC_RST;
    end else if (state_r == sst_pkg::S_EXEC && end_ph3) begin
      if (writes_dest && !dec_r.dest_f) acc_r <= alu_r.res;
    end else if (wr_ok && s_axi_awaddr == sst_pkg::OFF_ACC) begin
      acc_r <= 8'(sst_pkg::sst_wmerge({24'h000000, acc_r}, s_axi_wdata,
               s_axi_wstrb));
    end
  end

  // Only subtracts carry an update mask; swap, test and table read leave
  // the flags alone
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_r <= sst_pkg::FLAGS_RST;
    end else if (state_r == sst_pkg::S_EXEC && end_ph3) begin
      flags_r <= (flags_r & ~alu_r.upd) | (alu_r.flags & alu_r.upd);
    end else if (wr_ok && s_axi_awaddr == sst_pkg::OFF_STATUS) begin
      flags_r <= 5'(sst_pkg::sst_wmerge({27'h0000000, flags_r}, s_axi_wdata,
                 s_axi_wstrb));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Power-down and watchdog

  // Watchdog runs on its own from aclk, so it keeps counting in sleep
  always_ff @(posedge aclk) begin
    if (!aresetn) wdt_r <= 32'h00000000;
    else if (state_r == sst_pkg::S_EXEC && end_ph3 &&
             dec_r.op == sst_pkg::OP_SLEEP) wdt_r <= 32'h00000000;
    else if (wdt_hit) wdt_r <= 32'h00000000;
    else wdt_r <= wdt_r + 32'h00000001;
  end

  // Power-down wins over a timeout landing in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      to_r <= sst_pkg::TO_RST;
      pd_r <= sst_pkg::PD_RST;
    end else if (state_r == sst_pkg::S_EXEC && end_ph3 &&
                 dec_r.op == sst_pkg::OP_SLEEP) begin
      to_r <= 1'b1;
      pd_r <= 1'b0;
    end else if (wdt_hit) begin
      to_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Table pointer, latch and software address registers

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latch_r <= 8'h00;
    end else if (state_r == sst_pkg::S_TBL2 && end_ph1) begin
      latch_r <= rd_ptr[0] ? rd_word[15:8] : rd_word[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ptr_r <= sst_pkg::PTR_RST;
    end else if (state_r == sst_pkg::S_TBL2 && end_ph3) begin
      case (dec_r.nn)
        sst_pkg::NN_POSTINC, sst_pkg::NN_PREINC:
          ptr_r <= ptr_r + 21'h000001;
        sst_pkg::NN_POSTDEC: ptr_r <= ptr_r - 21'h000001;
        default: ptr_r <= ptr_r;
      endcase
    end else if (wr_ok && s_axi_awaddr == sst_pkg::OFF_PTR) begin
      ptr_r <= 21'(sst_pkg::sst_wmerge({11'h000, ptr_r}, s_axi_wdata,
               s_axi_wstrb));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bank_r <= sst_pkg::BANK_RST;
      daddr_r <= '0;
      paddr_r <= '0;
    end else if (wr_ok) begin
      if (s_axi_awaddr == sst_pkg::OFF_BANK && s_axi_wstrb[0])
        bank_r <= s_axi_wdata[sst_pkg::BANK_W-1:0];
      if (s_axi_awaddr == sst_pkg::OFF_DADDR)
        daddr_r <= DAW'(sst_pkg::sst_wmerge(32'(daddr_r), s_axi_wdata,
                   s_axi_wstrb));
      if (s_axi_awaddr == sst_pkg::OFF_PADDR)
        paddr_r <= PAW'(sst_pkg::sst_wmerge(32'(paddr_r), s_axi_wdata,
                   s_axi_wstrb));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel: address and data taken together

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready &&
                       !s_axi_bvalid;
      s_axi_wready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready &&
                      !s_axi_bvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel

  // Status shows busy, sleep, pending skip, timeout, power-down, flags
  always_comb begin
    rdata_nxt = 32'h00000000;
    case (s_axi_araddr)
      sst_pkg::OFF_INSTR: rdata_nxt = {16'h0000, instr_r};
      sst_pkg::OFF_STATUS: rdata_nxt = {22'h000000, !idle,
        state_r == sst_pkg::S_SLEEP, skip_r, to_r, pd_r, flags_r};
      sst_pkg::OFF_ACC: rdata_nxt = {24'h000000, acc_r};
      sst_pkg::OFF_BANK: rdata_nxt = 32'(bank_r);
      sst_pkg::OFF_PTR: rdata_nxt = {11'h000, ptr_r};
      sst_pkg::OFF_LATCH: rdata_nxt = {24'h000000, latch_r};
      sst_pkg::OFF_DADDR: rdata_nxt = 32'(daddr_r);
      sst_pkg::OFF_DDATA: rdata_nxt = {24'h000000, dmem[daddr_r]};
      sst_pkg::OFF_PADDR: rdata_nxt = 32'(paddr_r);
      sst_pkg::OFF_PDATA: rdata_nxt = {16'h0000, pmem[paddr_r]};
      default: rdata_nxt = 32'h00000000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) s_axi_arready <= 1'b0;
    else s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdata_nxt;
      s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : sst_exec

// >>> shared/sst_pkg.sv
package sst_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int ADDR_W = 8;
  localparam int BANK_W = 4;
  localparam int PTR_W = 21;
  localparam int PWORD_W = 16;
  localparam int PWORDS_DEF = 1024;
  localparam int PHASE_DIV_DEF = 1;

  ////////////////////////////////////////////////////////////////////////
  // Register byte offsets on the AXI4-Lite slave
  localparam logic [ADDR_W-1:0] OFF_INSTR = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_ACC = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_BANK = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_PTR = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_LATCH = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_DADDR = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_DDATA = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_PADDR = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_PDATA = 8'h24;

  // Arithmetic flag positions inside the five-bit flag field
  localparam int FL_C = 0;
  localparam int FL_DC = 1;
  localparam int FL_Z = 2;
  localparam int FL_OV = 3;
  localparam int FL_N = 4;
  localparam logic [4:0] FL_ALL = 5'h1F;

  // Values after reset
  localparam logic [4:0] FLAGS_RST = 5'h00;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [BANK_W-1:0] BANK_RST = 4'h0;
  localparam logic [PTR_W-1:0] PTR_RST = 21'h000000;
  localparam logic TO_RST = 1'b1;
  localparam logic PD_RST = 1'b1;
  localparam logic [31:0] WDT_CYCLES_DEF = 32'h00001000;

  // Opcode patterns, matched on the leading bits
  localparam logic [5:0] OPC_SUB = 6'h17;
  localparam logic [5:0] OPC_SUBB = 6'h16;
  localparam logic [5:0] OPC_SWAP = 6'h0E;
  localparam logic [6:0] OPC_TST = 7'h33;
  localparam logic [13:0] OPC_TBL = 14'h0002;
  localparam logic [15:0] OPC_SLEEP = 16'h0003;

  // Table pointer update modes
  localparam logic [1:0] NN_KEEP = 2'h0;
  localparam logic [1:0] NN_POSTINC = 2'h1;
  localparam logic [1:0] NN_POSTDEC = 2'h2;
  localparam logic [1:0] NN_PREINC = 2'h3;

  typedef enum logic [6:0] {
    OP_NOP = 7'h01, OP_SUB = 7'h02, OP_SUBB = 7'h04, OP_SWAP = 7'h08,
    OP_TST = 7'h10, OP_TBL = 7'h20, OP_SLEEP = 7'h40
  } sst_op_e;

  typedef enum logic [3:0] {
    S_IDLE = 4'h1, S_EXEC = 4'h2, S_TBL2 = 4'h4, S_SLEEP = 4'h8
  } sst_state_e;

  typedef struct packed {
    sst_op_e op;
    logic dest_f;
    logic bank_a;
    logic [7:0] faddr;
    logic [1:0] nn;
  } sst_dec_s;

  typedef struct packed {
    logic [7:0] res;
    logic [4:0] flags;
    logic [4:0] upd;
  } sst_alu_s;

  // Instruction word to operation and operand fields
  function automatic sst_dec_s sst_decode(logic [15:0] w);
    sst_dec_s d;
    d.op = OP_NOP;
    d.dest_f = w[9];
    d.bank_a = w[8];
    d.faddr = w[7:0];
    d.nn = w[1:0];
    if (w[15:10] == OPC_SUB) d.op = OP_SUB;
    else if (w[15:10] == OPC_SUBB) d.op = OP_SUBB;
    else if (w[15:10] == OPC_SWAP) d.op = OP_SWAP;
    else if (w[15:9] == OPC_TST) d.op = OP_TST;
    else if (w[15:2] == OPC_TBL) d.op = OP_TBL;
    else if (w == OPC_SLEEP) d.op = OP_SLEEP;
    return d;
  endfunction : sst_decode

  // Byte-lane merge of an AXI write into an old word
  function automatic logic [31:0] sst_wmerge(logic [31:0] old,
      logic [31:0] nw, logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction : sst_wmerge

endpackage : sst_pkg

// >>> rtl/sst_phase.sv
`timescale 1ns/100ps
module sst_phase #(
  parameter int DIV = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  output logic [1:0] ph,
  output logic tick
);

  logic [15:0] cnt_r;

  // Divider: one tick per phase; held at zero while stopped
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) cnt_r <= 16'h0000;
    else if (tick) cnt_r <= 16'h0000;
    else cnt_r <= cnt_r + 16'h0001;
  end

  assign tick = run && (cnt_r == 16'(DIV - 1));

  // Phase index restarts at the first phase every time run rises
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) ph <= 2'h0;
    else if (tick) ph <= ph + 2'h1;
  end

endmodule : sst_phase

// >>> rtl/sst_alu.sv
`timescale 1ns/100ps
module sst_alu (
  input wire sst_pkg::sst_op_e op,
  input wire logic [7:0] fval,
  input wire logic [7:0] acc,
  input wire logic carry,
  output sst_pkg::sst_alu_s o
);

  logic cin;
  logic [8:0] s;
  logic [4:0] lo;

  // Subtract as f + ~w + carry-in; carry out means no borrow
  always_comb begin
    cin = (op == sst_pkg::OP_SUBB) ? carry : 1'b1;
    s = {1'b0, fval} + {1'b0, ~acc} + {8'h00, cin};
    lo = {1'b0, fval[3:0]} + {1'b0, ~acc[3:0]} + {4'h0, cin};
    o = '0;
    o.res = fval;
    case (op)
      sst_pkg::OP_SUB, sst_pkg::OP_SUBB: begin
        o.res = s[7:0];
        o.upd = sst_pkg::FL_ALL;
        o.flags[sst_pkg::FL_C] = s[8];
        o.flags[sst_pkg::FL_DC] = lo[4];
        o.flags[sst_pkg::FL_Z] = (s[7:0] == 8'h00);
        o.flags[sst_pkg::FL_OV] = (fval[7] != acc[7]) && (s[7] != fval[7]);
        o.flags[sst_pkg::FL_N] = s[7];
      end
      sst_pkg::OP_SWAP: begin
        o.res = {fval[3:0], fval[7:4]};
      end
      default: begin
        o.res = fval;
      end
    endcase
  end

endmodule : sst_alu

// >>> tb/sst_exec_checker.sv
`timescale 1ns/100ps
module sst_exec_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [sst_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic [sst_pkg::ADDR_W-1:0] raddr_r;

  ////////////////////////////////////////////////////////////////////////
  // Remember which register the pending read answers
  always_ff @(posedge aclk) begin
    if (!aresetn) raddr_r <= 8'h00;
    else if (s_axi_arready) raddr_r <= s_axi_araddr;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // A write offered with no answer pending, and its completion
  sequence wr_offer;
    s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready;
  endsequence
  sequence wr_done;
    s_axi_bvalid && !s_axi_awready && !s_axi_wready;
  endsequence

  ////////////////////////////////////////////////////////////////////////
  aw_take_a: assert property (wr_offer |=> s_axi_awready && s_axi_wready)
    else $error("write not taken one cycle after offer");
  wr_resp_a: assert property (s_axi_awready |=> wr_done)
    else $error("write answer not one cycle after take");
  b_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer held after handshake");
  ar_take_a: assert property (s_axi_arvalid && !s_axi_arready
    && !s_axi_rvalid |=> s_axi_arready) else $error("read not taken");
  rd_resp_a: assert property (s_axi_arready |=> s_axi_rvalid
    && !s_axi_arready) else $error("read answer not one cycle after take");
  r_drop_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer held after handshake");
  acc_width_a: assert property (s_axi_rvalid && raddr_r == sst_pkg::OFF_ACC
    |-> s_axi_rdata[31:8] == 24'h000000) else $error("accumulator too wide");
  ptr_width_a: assert property (s_axi_rvalid && raddr_r == sst_pkg::OFF_PTR
    |-> s_axi_rdata[31:21] == 11'h000) else $error("pointer too wide");
  sleep_flags_a: assert property (s_axi_rvalid && s_axi_rdata[8]
    && raddr_r == sst_pkg::OFF_STATUS |-> s_axi_rdata[6:5] == 2'h2)
    else $error("asleep with wrong timeout or power-down flag");
endmodule : sst_exec_checker

bind sst_exec sst_exec_checker sst_exec_checker_inst (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_wvalid, .s_axi_awready, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);

// >>> tb/testbench.sv
`timescale 1ns/100ps
module testbench;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0;
  logic s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata, v;
  logic [1:0] tn [5] = '{2'h0, 2'h1, 2'h3, 2'h2, 2'h0};
  logic [7:0] tl [5] = '{8'h34, 8'h34, 8'hCD, 8'hCD, 8'h12};
  logic [7:0] tp [5] = '{8'h0A, 8'h0B, 8'h0C, 8'h0B, 8'h0B};
  int failures = 0;
  int checked = 0;

  // Short watchdog period so a sleep ends within a few register polls
  sst_exec #(.WDT_CYCLES(32'h00000020)) sst_exec_inst (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);

  initial forever #5 aclk = ~aclk;

  ////////////////////////////////////////////////////////////////////////
  task close_out;
    $display("failures=%0d checked=%0d", failures, checked);
    if (failures == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out

  task chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  // Every wait is bounded; running out counts as a mismatch
  task hang(input int n);
    if (n >= 60) begin
      failures++;
      close_out();
    end
  endtask : hang

  // Both write channels offered together, held until taken
  task wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      hang(n);
    end while (s_axi_awready !== 1'h1);
    s_axi_awvalid <= 1'h0;
    s_axi_wvalid <= 1'h0;
    do begin
      @(posedge aclk);
      n++;
      hang(n);
    end while (s_axi_bvalid !== 1'h1);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask : wr

  task rd(input logic [7:0] a);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      hang(n);
    end while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do begin
      @(posedge aclk);
      n++;
      hang(n);
    end while (s_axi_rvalid !== 1'h1);
    v = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask : rd

  // Poll one status bit until it reaches the wanted level
  task poll(input int b, input logic e);
    int n;
    n = 0;
    do begin
      rd(sst_pkg::OFF_STATUS);
      n++;
      hang(n);
    end while (v[b] !== e);
  endtask : poll

  task ex(input logic [15:0] i);
    wr(sst_pkg::OFF_INSTR, {16'h0000, i});
    poll(9, 1'h0);
  endtask : ex

  task wm(input logic [11:0] a, input logic [7:0] d);
    wr(sst_pkg::OFF_DADDR, {20'h00000, a});
    wr(sst_pkg::OFF_DDATA, {24'h000000, d});
  endtask : wm

  task cm(input logic [11:0] a, input logic [7:0] e);
    wr(sst_pkg::OFF_DADDR, {20'h00000, a});
    rd(sst_pkg::OFF_DDATA);
    chk(v, {24'h000000, e});
  endtask : cm

  task cs(input logic [4:0] e);
    rd(sst_pkg::OFF_STATUS);
    chk({27'h0000000, v[4:0]}, {27'h0000000, e});
  endtask : cs

  task ca(input logic [7:0] e);
    rd(sst_pkg::OFF_ACC);
    chk(v, {24'h000000, e});
  endtask : ca

  ////////////////////////////////////////////////////////////////////////
  // Main sequence: arithmetic, swap, table reads, skip, sleep
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    rd(sst_pkg::OFF_STATUS);
    chk(v, 32'h00000060);
    wr(sst_pkg::OFF_BANK, 32'h00000002);
    wm(12'h234, 8'h03);
    wr(sst_pkg::OFF_ACC, 32'h00000002);
    ex(16'h5F34);
    cm(12'h234, 8'h01);
    cs(5'h03);
    wm(12'h010, 8'h02);
    wm(12'h011, 8'h01);
    ex(16'h5C10);
    ca(8'h00);
    cs(5'h07);
    wr(sst_pkg::OFF_ACC, 32'h00000002);
    ex(16'h5C11);
    ca(8'hFF);
    cs(5'h10);
    // Borrow in, then no borrow in
    wr(sst_pkg::OFF_ACC, 32'h00000001);
    ex(16'h5810);
    ca(8'h00);
    wr(sst_pkg::OFF_ACC, 32'h00000001);
    ex(16'h5810);
    ca(8'h01);
    cs(5'h03);
    wm(12'h012, 8'h53);
    ex(16'h3A12);
    cm(12'h012, 8'h35);
    cs(5'h03);
    // Table reads in all four pointer modes
    wr(sst_pkg::OFF_PADDR, 32'h00000005);
    wr(sst_pkg::OFF_PDATA, 32'h00001234);
    wr(sst_pkg::OFF_PADDR, 32'h00000006);
    wr(sst_pkg::OFF_PDATA, 32'h0000ABCD);
    wr(sst_pkg::OFF_PTR, 32'h0000000A);
    for (int i = 0; i < 5; i++) begin
      ex({14'h0002, tn[i]});
      rd(sst_pkg::OFF_LATCH);
      chk(v, {24'h000000, tl[i]});
      rd(sst_pkg::OFF_PTR);
      chk(v, {24'h000000, tp[i]});
    end
    // Zero test skips the next instruction only when zero
    wm(12'h013, 8'h00);
    ex(16'h6613);
    rd(sst_pkg::OFF_STATUS);
    chk({31'h00000000, v[7]}, 32'h00000001);
    ex(16'h3A12);
    cm(12'h012, 8'h35);
    ex(16'h6610);
    ex(16'h3A12);
    cm(12'h012, 8'h53);
    cs(5'h03);
    wr(8'h40, 32'h00000001);
    chk({30'h00000000, r}, 32'h00000002);
    // Unmapped read answers an error with zero data
    rd(8'h40);
    chk({30'h00000000, r}, 32'h00000002);
    chk(v, 32'h00000000);
    // Power-down, refused write while asleep, watchdog wake
    wr(sst_pkg::OFF_INSTR, 32'h00000003);
    poll(8, 1'h1);
    chk({30'h00000000, v[6:5]}, 32'h00000002);
    wr(sst_pkg::OFF_ACC, 32'h00000005);
    chk({30'h00000000, r}, 32'h00000002);
    poll(8, 1'h0);
    chk({30'h00000000, v[6:5]}, 32'h00000000);
    close_out();
  end
endmodule : testbench
